// ---- hdl/pbwg_regs.svh ----
// Purpose: named constants of the peripheral bus wait generator
// Assumes: included by the design file and the testbench
// Notes:   register selects, fixed wait counts, divider exponents
`ifndef PBWG_REGS_SVH
`define PBWG_REGS_SVH

// register select codes on the access request
`define PBWG_SEL_NONE     4'h0
`define PBWG_SEL_WDT_MODE 4'h1
`define PBWG_SEL_SER0_RX  4'h2
`define PBWG_SEL_SER6_RX  4'h3
`define PBWG_SEL_CNV_MODE 4'h4
`define PBWG_SEL_CNV_CHAN 4'h5
`define PBWG_SEL_PF_MODE  4'h6
`define PBWG_SEL_PF_THR   4'h7
`define PBWG_SEL_CNV_RES  4'h8

// wait counts in cpu clock cycles
`define PBWG_WAIT_NONE    4'h0
`define PBWG_WAIT_ONE     4'h1
`define PBWG_WAIT_WDT     4'h3
`define PBWG_WAIT_SER     4'h1
`define PBWG_CNV_MIN_WR   4'h2
`define PBWG_CNV_MIN_RD   4'h1

// log2 of twice the cpu/macro clock ratio at fcpu = fx
`define PBWG_EXP_FAST     3'h2
`define PBWG_EXP_SLOW     3'h3

`endif

// ---- hdl/pbwg_pkg.sv ----
// Purpose: types of the peripheral bus wait generator
// Assumes: constants come from pbwg_regs.svh
// Notes:   request carrier and controller states
package pbwg_pkg;

	typedef struct packed {
		logic       write;
		logic [3:0] sel;
	} pbwg_access_type;

	typedef enum logic [1:0] {
		PBWG_IDLE = 2'b01,
		PBWG_WAIT = 2'b10
	} pbwg_state_type;

endpackage : pbwg_pkg

// ---- hdl/pbwg_wait_gen.sv ----
// Purpose: stalls cpu issue while a peripheral bus access settles
// Assumes: 50 % duty cpu clock, cpu clock = fx / 2^cpu_div_sel_in
// Notes:   the peripheral side raises ack once data has crossed
`include "pbwg_regs.svh"

// Functional notes
// - conflicting access is repeated until peripheral acknowledges valid data after the minimum wait, or the maximum is reached.
// - next instruction held off exactly as many cycles as waits inserted.
// - watchdog mode register write inserts exactly three waits while the main clock runs.
// - either serial receive status read inserts exactly one wait while the main clock runs.
// - converter control writes wait 2..5 when speed bit set, else 2..9.
// - maximum wait is two macro periods in cpu periods plus one.
// - macro clock is fx/2 with speed bit set, fx/4 otherwise.
// - a computed converter maximum of one inserts no wait at all.
// - every wait count is measured in cpu clock cycles.
module pbwg_wait_gen (
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic                     ce_in,
	input  wire logic                     acc_valid_in,
	input  wire pbwg_pkg::pbwg_access_type acc_in,
	input  wire logic                     converter_speed_bit_in,
	input  wire logic [2:0]               cpu_div_sel_in,
	input  wire logic                     main_clock_stop_ctrl_in,
	input  wire logic                     periph_ack_in,
	output logic                          stall_out,
	output logic                          done_out,
	output logic [3:0]                    wait_count_out,
	output logic                          misuse_out
);

	pbwg_pkg::pbwg_state_type state_q;
	logic [3:0] cnt_q;
	logic [3:0] min_q;
	logic [3:0] max_q;
	logic [2:0] ack_sync_q;
	logic       ack_q;
	logic [3:0] stall_run_q;

	// request decode
	wire       is_wdt  = acc_in.write && acc_in.sel == `PBWG_SEL_WDT_MODE;
	wire       is_ser  = !acc_in.write &&
	                     (acc_in.sel == `PBWG_SEL_SER0_RX ||
	                      acc_in.sel == `PBWG_SEL_SER6_RX);
	wire       is_cwr  = acc_in.write &&
	                     acc_in.sel >= `PBWG_SEL_CNV_MODE &&
	                     acc_in.sel <= `PBWG_SEL_PF_THR;
	wire       is_crd  = !acc_in.write && acc_in.sel == `PBWG_SEL_CNV_RES;

	// macro clock is fx/2 or fx/4, so 2*fcpu/converter_macro_freq = 2^(exp - div)
	wire [2:0] cnv_exp = converter_speed_bit_in ?
	                     `PBWG_EXP_FAST : `PBWG_EXP_SLOW;
	wire       in_rng  = cpu_div_sel_in <= cnv_exp;
	wire [2:0] shift   = cnv_exp - cpu_div_sel_in;
	wire [3:0] pow     = `PBWG_WAIT_ONE << shift;
	// fractions are 1/2 cycle or less, never above the low width: dropped
	wire [3:0] cnv_max = in_rng ? pow + `PBWG_WAIT_ONE :
	                     `PBWG_WAIT_ONE;
	wire       cnv_gen = cnv_max != `PBWG_WAIT_ONE;

	wire [3:0] req_max = is_wdt ? `PBWG_WAIT_WDT :
	                     is_ser ? `PBWG_WAIT_SER :
	                     ((is_cwr || is_crd) && cnv_gen) ? cnv_max :
	                     `PBWG_WAIT_NONE;
	wire [3:0] req_min = is_wdt ? `PBWG_WAIT_WDT :
	                     is_ser ? `PBWG_WAIT_SER :
	                     is_cwr ? `PBWG_CNV_MIN_WR :
	                     `PBWG_CNV_MIN_RD;
	wire       wait_req = req_max != `PBWG_WAIT_NONE;

	wire       idle    = state_q == pbwg_pkg::PBWG_IDLE;
	wire       accept  = ce_in && idle && acc_valid_in;
	// with the main clock stopped no crossing would ever finish
	wire       bad_acc = accept && wait_req && main_clock_stop_ctrl_in;
	wire       go_wait = accept && wait_req && !main_clock_stop_ctrl_in;
	wire       finish  = cnt_q == max_q ||
	                     (cnt_q >= min_q && ack_q);
	wire       leave   = ce_in && !idle && finish;

	// ack from the slow bus: accept a change once stages 2 and 3 agree
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ack_sync_q <= 3'h0;
			ack_q      <= 1'b0;
		end
		else if (ce_in)
		begin
			ack_sync_q <= {ack_sync_q[1:0], periph_ack_in};
			if (ack_sync_q[1] == ack_sync_q[2])
				ack_q <= ack_sync_q[2];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_q <= pbwg_pkg::PBWG_IDLE;
			cnt_q   <= `PBWG_WAIT_NONE;
			min_q   <= `PBWG_WAIT_NONE;
			max_q   <= `PBWG_WAIT_NONE;
		end
		else if (ce_in)
		begin
			case (state_q)
				pbwg_pkg::PBWG_IDLE:
				begin
					if (go_wait)
					begin
						state_q <= pbwg_pkg::PBWG_WAIT;
						cnt_q   <= `PBWG_WAIT_ONE;
						min_q   <= req_min;
						max_q   <= req_max;
					end
				end
				pbwg_pkg::PBWG_WAIT:
				begin
					if (finish)
						state_q <= pbwg_pkg::PBWG_IDLE;
					else
						cnt_q <= cnt_q + `PBWG_WAIT_ONE;
				end
				default:
					state_q <= pbwg_pkg::PBWG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			stall_out      <= 1'b0;
			done_out       <= 1'b0;
			wait_count_out <= `PBWG_WAIT_NONE;
			misuse_out     <= 1'b0;
		end
		else if (ce_in)
		begin
			stall_out <= go_wait || (!idle && !finish);
			done_out  <= (accept && !go_wait) || leave;
			if (accept && !go_wait)
				wait_count_out <= `PBWG_WAIT_NONE;
			else if (leave)
				wait_count_out <= cnt_q;
			if (bad_acc)
				misuse_out <= 1'b1;
		end
	end

	// helper: length of the current stall run
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			stall_run_q <= 4'h0;
		else if (ce_in)
			stall_run_q <= stall_out ? stall_run_q + 4'h1 : 4'h0;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_taken(cond);
		accept && cond && !main_clock_stop_ctrl_in;
	endsequence

	sequence s_ended;
		ce_in && done_out;
	endsequence

	a_wdt_three_waits: assert property (
		s_taken(is_wdt) ##1 (stall_out && ce_in)[*3] |=>
			!stall_out && done_out && wait_count_out == 4'h3)
	else $error("watchdog write did not wait three cycles");

	a_wdt_total: assert property (
		s_taken(is_wdt) ##1 ce_in[*4] |->
			done_out && wait_count_out == 4'h3)
	else $error("watchdog write wait count wrong");

	a_serial_one: assert property (
		s_taken(is_ser) ##1 ce_in[*2] |->
			done_out && wait_count_out == 4'h1 && !stall_out)
	else $error("serial status read wait count wrong");

	a_conv_wr_range: assert property (
		s_taken(is_cwr && cnv_gen) |->
			##[2:30] (done_out && wait_count_out >= 4'h2 &&
			          wait_count_out <= max_q))
	else $error("converter write wait out of range");

	a_result_one_skip: assert property (
		accept && is_crd && !cnv_gen |=>
			done_out && !stall_out && wait_count_out == 4'h0)
	else $error("result read waited with maximum of one");

	a_macro_max: assert property (
		converter_speed_bit_in && cpu_div_sel_in == 3'h0 |->
			cnv_max == 4'h5)
	else $error("fast macro clock maximum not five");

	a_slow_max: assert property (
		!converter_speed_bit_in && cpu_div_sel_in == 3'h1 |->
			cnv_max == 4'h5)
	else $error("slow macro maximum wrong at fx/2");

	a_stall_matches: assert property (
		(s_ended and (wait_count_out != 4'h0)) |->
			stall_run_q == wait_count_out)
	else $error("stall length differs from reported waits");

	a_ack_ends: assert property (
		ce_in && !idle && ack_q && cnt_q >= min_q |=>
			idle || !ce_in)
	else $error("wait continued after acknowledged data");

	a_misuse_flag: assert property (
		bad_acc |=> misuse_out && !stall_out && done_out)
	else $error("waiting access with stopped clock not flagged");

endmodule : pbwg_wait_gen

// ---- sim/pbwg_periph_model.sv ----
// Purpose: far side of the wait generator, the slow peripheral bus
// Assumes: prompt_in is held steady across each run of accesses
// Notes:   prompt_in low never acks, so converter waits run to maximum
module pbwg_periph_model (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic prompt_in,
	output logic      ack_out
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ack_out <= 1'b0;
		else
			ack_out <= prompt_in;
	end
endmodule : pbwg_periph_model

// ---- sim/tb.sv ----
// Purpose: random access stream against the wait generator
// Assumes: clock enable drops at random only while an access waits
// Notes:   expected waits queue up, a watcher compares on done_out
`include "pbwg_regs.svh"
`define CHK(nm, e, s) begin compares++; if ((e) !== (s)) begin \
	n_mismatch++; $display("unexpected %s exp %0h got %0h", nm, e, s); \
	end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      clk_in = 1'b0, rst_n_in = 1'b0;
	logic                      acc_valid_in = 1'b0, ce = 1'b1, ce_seen;
	logic                      speed = 1'b0, main_clock_stop_ctrl = 1'b0, prompt = 1'b0, ack;
	logic [2:0]                div = 3'h0;
	pbwg_pkg::pbwg_access_type acc_in = '0;
	logic                      stall_out, done_out, misuse_out;
	logic [3:0]                wait_count_out;
	logic [3:0]                q[$];
	logic [3:0]                e;
	int                        n_mismatch = 0, compares = 0, cyc = 0, st = 0;
	int                        seed = 32'h57004F34;
	pbwg_wait_gen u_pbwg_wait_gen (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.ce_in(ce), .acc_valid_in(acc_valid_in), .acc_in(acc_in),
		.converter_speed_bit_in(speed), .cpu_div_sel_in(div),
		.main_clock_stop_ctrl_in(main_clock_stop_ctrl), .periph_ack_in(ack),
		.stall_out(stall_out), .done_out(done_out),
		.wait_count_out(wait_count_out), .misuse_out(misuse_out));
	pbwg_periph_model u_pbwg_periph_model (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .prompt_in(prompt), .ack_out(ack));
	initial
	begin
		forever #4 clk_in = ~clk_in;
	end
	function automatic logic [3:0] exp_wait(logic w, logic [3:0] s);
		int k, m, mx;
		logic [3:0] r;
		k = speed ? 2 : 3;
		mx = (div > k) ? 1 : (1 << (k - div)) + 1;
		m = w ? 2 : 1;
		r = `PBWG_WAIT_NONE;
		if (w && s == `PBWG_SEL_WDT_MODE)
			r = `PBWG_WAIT_WDT;
		else if (!w && (s == `PBWG_SEL_SER0_RX || s == `PBWG_SEL_SER6_RX))
			r = `PBWG_WAIT_SER;
		else if ((w && s >= 4 && s <= 7) || (!w && s == `PBWG_SEL_CNV_RES))
			r = (mx == 1) ? 0 : (prompt && m < mx) ? m : mx;
		if (main_clock_stop_ctrl)
			r = 0;
		return r;
	endfunction : exp_wait
	task automatic summarize;
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task automatic access(input logic w, input logic [3:0] s);
		int k;
		acc_in = '{write: w, sel: s};
		q.push_back(exp_wait(w, s));
		acc_valid_in = 1'b1;
		@(negedge clk_in);
		acc_valid_in = 1'b0;
		// the request edge always runs; frozen cycles come only later
		for (k = 0; k < 40 && done_out !== 1'b1; k++)
		begin
			ce = ($random(seed) & 7) != 0;
			@(negedge clk_in);
		end
		ce = 1'b1;
		@(negedge clk_in);
	endtask : access
	// the watcher counts stall cycles so a short or long hold shows up
	always @(negedge clk_in)
	begin
		// a frozen cycle repeats the last outputs and is no wait
		if (ce_seen && rst_n_in && done_out === 1'b1 && q.size() > 0)
		begin
			e = q.pop_front();
			`CHK("wait_count", e, wait_count_out)
			`CHK("stall_len", e, 4'(st))
			st = 0;
		end
		else if (ce_seen === 1'b1 && stall_out === 1'b1)
			st++;
	end
	always @(posedge clk_in)
	begin
		ce_seen <= ce;
		cyc++;
		if (cyc >= 10000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	initial
	begin
		repeat (8) @(negedge clk_in);
		rst_n_in = 1'b1;
		for (int i = 0; i < 240; i++)
		begin
			if (i % 60 == 0)
			begin
				prompt = i[6];
				main_clock_stop_ctrl = (i >= 220);
				repeat (4) @(negedge clk_in); // let ack cross the sync
			end
			speed = 1'($random(seed));
			div = 3'($unsigned($random(seed)) % 5);
			access(1'($random(seed)), 4'($unsigned($random(seed)) % 10));
			if (i == 219)
				`CHK("misuse_early", 1'b0, misuse_out)
		end
		main_clock_stop_ctrl = 1'b1;
		access(1'b1, `PBWG_SEL_WDT_MODE);
		`CHK("misuse", 1'b1, misuse_out)
		`CHK("queue_empty", 1'b1, q.size() == 0)
		summarize();
	end
endmodule : tb
